/* dcf_chk.sv */
// Checker for flag timing, mailbox flags and port outputs
`timescale 1ns/10ps
`default_nettype none
module dcf_chk (
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        writePortClock,
	input wire logic        readPortClock,
	input wire logic        portASelectN,
	input wire logic        portAWriteSel,
	input wire logic        portAMailSel,
	input wire logic        portADataOe,
	input wire logic        portBSelectN,
	input wire logic        portBEnable,
	input wire logic        portBReadSel,
	input wire logic        portBMailSel,
	input wire logic        portBDataOe,
	input wire logic [35:0] portBDataOut,
	input wire logic        fullFlagN,
	input wire logic        almostFullFlagN,
	input wire logic        emptyFlagN,
	input wire logic        almostEmptyFlagN,
	input wire logic        mail1FlagN,
	input wire logic        mail2FlagN
);
	logic       aPrev_r;
	logic       bPrev_r;
	logic [3:0] aAge_r;
	logic [3:0] bAge_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// Cycles since each port clock last rose
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			aPrev_r <= 1'b0;
			bPrev_r <= 1'b0;
			aAge_r <= 4'hF;
			bAge_r <= 4'hF;
		end else begin
			aPrev_r <= writePortClock;
			bPrev_r <= readPortClock;
			aAge_r <= (writePortClock && !aPrev_r) ? 4'h0 :
				(aAge_r == 4'hF) ? aAge_r : aAge_r + 4'h1;
			bAge_r <= (readPortClock && !bPrev_r) ? 4'h0 :
				(bAge_r == 4'hF) ? bAge_r : bAge_r + 4'h1;
		end
	end
	a_full_almost: assert property (!fullFlagN |-> !almostFullFlagN)
		else $error("full shown without almost-full");
	a_empty_almost: assert property (!emptyFlagN |-> !almostEmptyFlagN)
		else $error("empty shown without almost-empty");
	a_full_aedge: assert property ($changed(fullFlagN) ||
		$changed(almostFullFlagN) |-> aAge_r <= 4'h6)
		else $error("full flags moved away from a port A edge");
	a_empty_bedge: assert property ($changed(emptyFlagN) ||
		$changed(almostEmptyFlagN) |-> bAge_r <= 4'h6)
		else $error("empty flags moved away from a port B edge");
	a_oe_a: assert property ($rose(portADataOe) |->
		!portASelectN && !portAWriteSel)
		else $error("port A driven without a read select");
	a_oe_b_off: assert property ($rose(portBSelectN) |->
		##[1:4] !portBDataOe)
		else $error("port B still driven after deselect");
	a_mail1_set: assert property ($fell(mail1FlagN) |->
		!$past(portASelectN, 3) && $past(portAWriteSel, 3) &&
		$past(portAMailSel, 3))
		else $error("mail1 flag set without a port A mail write");
	a_mail1_clr: assert property ($rose(mail1FlagN) |->
		!$past(portBSelectN, 3) && $past(portBReadSel, 3) &&
		$past(portBMailSel, 3))
		else $error("mail1 flag cleared without a port B mail read");
	a_mail2_set: assert property ($fell(mail2FlagN) |->
		!$past(portBSelectN, 3) && !$past(portBReadSel, 3) &&
		$past(portBMailSel, 3))
		else $error("mail2 flag set without a port B mail write");
	a_bout_qual: assert property ($changed(portBDataOut) |->
		!$past(portBSelectN, 3) && $past(portBEnable, 3))
		else $error("port B output changed without a qualified edge");
endmodule // dcf_chk
`default_nettype wire

/* dcf_defines.vh */
// Constants for the dual-port 64x36 FIFO with mailboxes
`ifndef DCF_DEFINES_VH
`define DCF_DEFINES_VH
`define DCF_WIDTH 36
`define DCF_DEPTH 7'h40
`define DCF_PTR_W 7
`define DCF_ADDR_W 6
`define DCF_STAGE_DEPTH 4
`define DCF_STAGE_LOG 2
`define DCF_PIN_IDLE 41'h18000000000
`define DCF_OFFSET_0 7'h04
`define DCF_OFFSET_1 7'h08
`define DCF_OFFSET_2 7'h10
`define DCF_OFFSET_3 7'h20
`define DCF_WARM_EDGES 2'h2
`define DCF_CAP_WAIT 2'h2
`define DCF_REG_CTRL 4'h0
`define DCF_REG_STATUS 4'h4
`define DCF_REG_COUNT 4'h8
`define DCF_CTRL_RESET 3'h0
`define DCF_CTRL_ODD_BIT 0
`define DCF_CTRL_GENA_BIT 1
`define DCF_CTRL_GENB_BIT 2
`define DCF_RESP_OKAY 2'h0
`define DCF_RESP_DECERR 2'h3
`endif

/* dcf_port_model.sv */
// Port-side bus master with its own free-running port clock
`timescale 1ns/10ps
`default_nettype none
module dcf_port_model #(
	parameter PER = 8
) (
	input  wire logic        coreClk,
	output wire logic        portClk,
	output var  logic        selN,
	output var  logic        en,
	output var  logic        dirSel,
	output var  logic        mailSel,
	output var  logic [35:0] drive,
	input  wire logic [35:0] dout
);
	int cnt = 0;
	initial begin
		selN = 1'b1;
		en = 1'b0;
		dirSel = 1'b0;
		mailSel = 1'b0;
		drive = 36'h0;
	end
	always @(posedge coreClk) cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
	assign portClk = (cnt >= PER / 2);
	// One transfer, pins held across the port clock rise
	task xfer(input logic d, input logic m, input logic [35:0] w,
		output logic [35:0] r);
		@(posedge coreClk iff cnt == PER - 1);
		selN <= 1'b0;
		en <= 1'b1;
		dirSel <= d;
		mailSel <= m;
		drive <= w;
		repeat (PER) @(posedge coreClk);
		selN <= 1'b1;
		en <= 1'b0;
		drive <= ~w;
		repeat (2) @(posedge coreClk);
		r = dout;
	endtask
endmodule // dcf_port_model
`default_nettype wire

/* dcf_stub_unused.v */
// Spare design file; the whole block lives in the top design file

/* dcf_top.v */
// Dual-port 64x36 FIFO with mailboxes, parity and AXI4-Lite status
// Notes on behaviour
// - Holds 64 words of 36 bits, passed in order from port A to B.
// - Almost-empty low while stored count is at or below the offset.
// - Almost-full low while free count is at or below the offset.
// - Full flags built on port A side from twice-synchronised read progress.
// - Empty flags built on port B side from twice-synchronised write progress.
// - Transfers only at a port clock rising edge qualified by its enables.
// - Ports independent; same-edge write and read both work.
// - Each port is a 36-bit two-way bus, driven by the device on reads.
// - Two 36-bit mailboxes, one per direction, bypass the FIFO store.
// - Each mailbox flag shows a freshly written word waiting.
// - Parity on incoming data checked, never altering the data flow.
// - Per-port selectable parity generation on read data.
// - Port A work and full flag changes follow port A clock edges.
// - Port B work and empty flag changes follow port B clock edges.
// - Empty low at reset and when empty; high second B edge after fill.
// - Full low at reset and when full; high second A edge after reset.
// - Offset selects captured at reset release choose one of four offsets.
`include "dcf_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module dcf_fifo #(
	parameter WIDTH = 36,
	parameter DEPTH = 4,
	parameter LOG   = 2
) (
	input  wire             clk,
	input  wire             rstN,
	input  wire             inValid,
	output wire             inReady,
	input  wire [WIDTH-1:0] inData,
	output wire             outValid,
	input  wire             outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [LOG:0]     wrPtr_r;
	reg [LOG:0]     rdPtr_r;
	wire            isEmpty;
	wire            isFull;

	assign isEmpty  = (wrPtr_r == rdPtr_r);
	assign isFull   = (wrPtr_r[LOG] != rdPtr_r[LOG]) &&
		(wrPtr_r[LOG-1:0] == rdPtr_r[LOG-1:0]);
	assign inReady  = ~isFull;
	assign outValid = ~isEmpty;
	assign outData  = store[rdPtr_r[LOG-1:0]];

	always @(posedge clk) begin
		if (inValid && !isFull) begin
			store[wrPtr_r[LOG-1:0]] <= inData;
		end
	end

	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			wrPtr_r <= {(LOG+1){1'b0}};
			rdPtr_r <= {(LOG+1){1'b0}};
		end else begin
			if (inValid && !isFull) begin
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (outReady && !isEmpty) begin
				rdPtr_r <= rdPtr_r + 1'b1;
			end
		end
	end
endmodule // dcf_fifo

module dcf_top (
	input  wire        core_clk,
	input  wire        arst_n,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        writePortClock,
	input  wire        portASelectN,
	input  wire        portAEnable,
	input  wire        portAWriteSel,
	input  wire        portAMailSel,
	input  wire [35:0] portADataIn,
	output reg  [35:0] portADataOut,
	output reg         portADataOe,
	input  wire        readPortClock,
	input  wire        portBSelectN,
	input  wire        portBEnable,
	input  wire        portBReadSel,
	input  wire        portBMailSel,
	input  wire [35:0] portBDataIn,
	output reg  [35:0] portBDataOut,
	output reg         portBDataOe,
	input  wire        offsetSelect0,
	input  wire        offsetSelect1,
	output reg         fullFlagN,
	output reg         almostFullFlagN,
	output reg         emptyFlagN,
	output reg         almostEmptyFlagN,
	output reg         mail1FlagN,
	output reg         mail2FlagN,
	output reg         parityErrAN,
	output reg         parityErrBN
);
	function [6:0] toGray;
		input [6:0] b;
		toGray = b ^ (b >> 1);
	endfunction

	function [6:0] fromGray;
		input [6:0] g;
		integer i;
		begin
			fromGray[6] = g[6];
			for (i = 5; i >= 0; i = i - 1) begin
				fromGray[i] = fromGray[i+1] ^ g[i];
			end
		end
	endfunction

	function parityOk;
		input [35:0] d;
		input        odd;
		integer i;
		begin
			parityOk = 1'b1;
			for (i = 0; i < 4; i = i + 1) begin
				if ((^d[9*i +: 9]) != odd) begin
					parityOk = 1'b0;
				end
			end
		end
	endfunction

	function [35:0] parityGen;
		input [35:0] d;
		input        odd;
		input        en;
		integer i;
		begin
			parityGen = d;
			for (i = 0; i < 4; i = i + 1) begin
				if (en) begin
					parityGen[9*i+8] = (^d[9*i +: 8]) ^ odd;
				end
			end
		end
	endfunction

	// Pin synchronisers
	reg  [40:0] aS1_r;
	reg  [40:0] aS2_r;
	reg         aClkD_r;
	reg  [40:0] bS1_r;
	reg  [40:0] bS2_r;
	reg         bClkD_r;
	reg  [1:0]  fsS1_r;
	reg  [1:0]  fsS2_r;

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			// Idle levels, so a high port clock is no edge
			aS1_r   <= `DCF_PIN_IDLE;
			aS2_r   <= `DCF_PIN_IDLE;
			aClkD_r <= 1'b1;
			bS1_r   <= `DCF_PIN_IDLE;
			bS2_r   <= `DCF_PIN_IDLE;
			bClkD_r <= 1'b1;
			fsS1_r  <= 2'h0;
			fsS2_r  <= 2'h0;
		end else begin
			aS1_r   <= {writePortClock, portASelectN, portAEnable,
				portAWriteSel, portAMailSel, portADataIn};
			aS2_r   <= aS1_r;
			aClkD_r <= aS2_r[40];
			bS1_r   <= {readPortClock, portBSelectN, portBEnable,
				portBReadSel, portBMailSel, portBDataIn};
			bS2_r   <= bS1_r;
			bClkD_r <= bS2_r[40];
			fsS1_r  <= {offsetSelect1, offsetSelect0};
			fsS2_r  <= fsS1_r;
		end
	end

	wire        aEdge  = aS2_r[40] & ~aClkD_r;
	wire        bEdge  = bS2_r[40] & ~bClkD_r;
	wire        aGo    = aEdge & ~aS2_r[39] & aS2_r[38];
	wire        bGo    = bEdge & ~bS2_r[39] & bS2_r[38];
	wire        aWrite = aS2_r[37];
	wire        aMail  = aS2_r[36];
	wire        bRead  = bS2_r[37];
	wire        bMail  = bS2_r[36];
	wire [35:0] aData  = aS2_r[35:0];
	wire [35:0] bData  = bS2_r[35:0];

	// Control and offset registers
	reg  [2:0]  ctrl_r;
	reg  [6:0]  offset_r;
	reg  [1:0]  capCnt_r;

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			offset_r <= `DCF_OFFSET_0;
			capCnt_r <= 2'h0;
		end else if (capCnt_r != `DCF_CAP_WAIT + 2'h1) begin
			capCnt_r <= capCnt_r + 2'h1;
			if (capCnt_r == `DCF_CAP_WAIT) begin
				case (fsS2_r)
				2'h0: offset_r <= `DCF_OFFSET_0;
				2'h1: offset_r <= `DCF_OFFSET_1;
				2'h2: offset_r <= `DCF_OFFSET_2;
				default: offset_r <= `DCF_OFFSET_3;
				endcase
			end
		end
	end

	wire oddPar = ctrl_r[`DCF_CTRL_ODD_BIT];
	wire genA   = ctrl_r[`DCF_CTRL_GENA_BIT];
	wire genB   = ctrl_r[`DCF_CTRL_GENB_BIT];

	// Staging buffer in front of the main store
	wire        stgInReady;
	wire        stgOutValid;
	wire [35:0] stgOutData;
	wire        stgPush = aGo & aWrite & ~aMail & fullFlagN;
	wire        stgPop;

	dcf_fifo #(
		.WIDTH (`DCF_WIDTH),
		.DEPTH (`DCF_STAGE_DEPTH),
		.LOG   (`DCF_STAGE_LOG)
	) dcf_fifo_inst (
		.clk      (core_clk),
		.rstN     (arst_n),
		.inValid  (stgPush),
		.inReady  (stgInReady),
		.inData   (aData),
		.outValid (stgOutValid),
		.outReady (stgPop),
		.outData  (stgOutData)
	);

	// Main store and pointers
	reg  [35:0] mem [0:63];
	reg  [6:0]  wPtr_r;
	reg  [6:0]  wGray_r;
	reg  [6:0]  rPtr_r;
	reg  [6:0]  rGray_r;
	reg  [6:0]  rSyncA1_r;
	reg  [6:0]  rSyncA2_r;
	reg  [6:0]  wSyncB1_r;
	reg  [6:0]  wSyncB2_r;
	reg  [1:0]  aWarm_r;

	wire [6:0]  wrCount = wPtr_r - fromGray(rSyncA2_r);
	wire [6:0]  freeCnt = `DCF_DEPTH - wrCount;
	wire [6:0]  rdCount = fromGray(wSyncB2_r) - rPtr_r;
	wire        bFifoRd = bGo & bRead & ~bMail & emptyFlagN;

	assign stgPop = stgOutValid & (wrCount != `DCF_DEPTH);

	always @(posedge core_clk) begin
		if (stgPop) begin
			mem[wPtr_r[5:0]] <= stgOutData;
		end
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wPtr_r    <= 7'h00;
			wGray_r   <= 7'h00;
			rPtr_r    <= 7'h00;
			rGray_r   <= 7'h00;
			rSyncA1_r <= 7'h00;
			rSyncA2_r <= 7'h00;
			wSyncB1_r <= 7'h00;
			wSyncB2_r <= 7'h00;
			aWarm_r   <= 2'h0;
		end else begin
			if (stgPop) begin
				wPtr_r  <= wPtr_r + 7'h01;
				wGray_r <= toGray(wPtr_r + 7'h01);
			end
			if (bFifoRd) begin
				rPtr_r  <= rPtr_r + 7'h01;
				rGray_r <= toGray(rPtr_r + 7'h01);
			end
			if (aEdge) begin
				rSyncA1_r <= rGray_r;
				rSyncA2_r <= rSyncA1_r;
				if (aWarm_r != `DCF_WARM_EDGES) begin
					aWarm_r <= aWarm_r + 2'h1;
				end
			end
			if (bEdge) begin
				wSyncB1_r <= wGray_r;
				wSyncB2_r <= wSyncB1_r;
			end
		end
	end

	// Flags, mailboxes and port outputs
	reg  [35:0] mail1_r;
	reg  [35:0] mail2_r;
	wire        aWarmed = (aWarm_r == `DCF_WARM_EDGES);

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			fullFlagN        <= 1'b0;
			almostFullFlagN  <= 1'b0;
			emptyFlagN       <= 1'b0;
			almostEmptyFlagN <= 1'b0;
			mail1FlagN       <= 1'b1;
			mail2FlagN       <= 1'b1;
			mail1_r          <= 36'h0;
			mail2_r          <= 36'h0;
			portADataOut     <= 36'h0;
			portADataOe      <= 1'b0;
			portBDataOut     <= 36'h0;
			portBDataOe      <= 1'b0;
			parityErrAN      <= 1'b1;
			parityErrBN      <= 1'b1;
		end else begin
			fullFlagN        <= aWarmed & (wrCount != `DCF_DEPTH);
			almostFullFlagN  <= aWarmed & (freeCnt > offset_r);
			emptyFlagN       <= (rdCount != 7'h00);
			almostEmptyFlagN <= (rdCount > offset_r);
			portADataOe      <= ~aS2_r[39] & ~aWrite;
			portBDataOe      <= ~bS2_r[39] & bRead;
			parityErrAN      <= ~(~aS2_r[39] & aWrite &
				~parityOk(aData, oddPar));
			parityErrBN      <= ~(~bS2_r[39] & ~bRead &
				~parityOk(bData, oddPar));
			if (aGo && aWrite && aMail && mail1FlagN) begin
				mail1_r    <= aData;
				mail1FlagN <= 1'b0;
			end else if (bGo && bRead && bMail) begin
				mail1FlagN <= 1'b1;
			end
			if (bGo && !bRead && bMail && mail2FlagN) begin
				mail2_r    <= bData;
				mail2FlagN <= 1'b0;
			end else if (aGo && !aWrite && aMail) begin
				mail2FlagN <= 1'b1;
			end
			if (aGo && !aWrite) begin
				portADataOut <= parityGen(mail2_r, oddPar, genA);
			end
			if (bGo && bRead && bMail) begin
				portBDataOut <= parityGen(mail1_r, oddPar, genB);
			end else if (bFifoRd) begin
				portBDataOut <= parityGen(mem[rPtr_r[5:0]], oddPar,
					genB);
			end
		end
	end

	// AXI4-Lite slave
	reg  [3:0]  awAddr_r;
	reg         awHave_r;
	reg  [31:0] wData_r;
	reg         wLow_r;
	reg         wHave_r;
	reg  [31:0] rdVal;
	reg         rdHit;

	always @* begin
		rdVal = 32'h0;
		rdHit = 1'b1;
		case (s_axi_araddr)
		`DCF_REG_CTRL: rdVal = {29'h0, ctrl_r};
		`DCF_REG_STATUS: rdVal = {17'h0, offset_r, parityErrBN,
			parityErrAN, mail2FlagN, mail1FlagN, almostEmptyFlagN,
			emptyFlagN, almostFullFlagN, fullFlagN};
		`DCF_REG_COUNT: rdVal = {25'h0, rdCount};
		default: rdHit = 1'b0;
		endcase
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `DCF_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `DCF_RESP_OKAY;
			s_axi_rdata   <= 32'h0;
			awAddr_r      <= 4'h0;
			awHave_r      <= 1'b0;
			wData_r       <= 32'h0;
			wLow_r        <= 1'b0;
			wHave_r       <= 1'b0;
			ctrl_r        <= `DCF_CTRL_RESET;
		end else begin
			s_axi_awready <= ~awHave_r & ~s_axi_bvalid &
				~(s_axi_awready & s_axi_awvalid);
			s_axi_wready  <= ~wHave_r & ~s_axi_bvalid &
				~(s_axi_wready & s_axi_wvalid);
			if (s_axi_awready && s_axi_awvalid) begin
				awAddr_r <= s_axi_awaddr;
				awHave_r <= 1'b1;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				wData_r <= s_axi_wdata;
				wLow_r  <= s_axi_wstrb[0];
				wHave_r <= 1'b1;
			end
			if (awHave_r && wHave_r && !s_axi_bvalid) begin
				awHave_r     <= 1'b0;
				wHave_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awAddr_r == `DCF_REG_CTRL) begin
					s_axi_bresp <= `DCF_RESP_OKAY;
					if (wLow_r) begin
						ctrl_r <= wData_r[2:0];
					end
				end else if (awAddr_r == `DCF_REG_STATUS ||
					awAddr_r == `DCF_REG_COUNT) begin
					s_axi_bresp <= `DCF_RESP_OKAY;
				end else begin
					s_axi_bresp <= `DCF_RESP_DECERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= ~s_axi_rvalid &
				~(s_axi_arready & s_axi_arvalid);
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdVal;
				s_axi_rresp  <= rdHit ? `DCF_RESP_OKAY :
					`DCF_RESP_DECERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	wire unusedBits = &{stgInReady, s_axi_wstrb[3:1], 1'b0};
endmodule // dcf_top
`default_nettype wire

/* dcf_top_bench.sv */
// Self-checking bench for the dual-port FIFO block
`timescale 1ns/10ps
`default_nettype none
module dcf_top_bench;
	logic        core_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, offsetSelect0;
	logic        offsetSelect1, portADataOe, portBDataOe, fullFlagN;
	logic        almostFullFlagN, emptyFlagN, almostEmptyFlagN;
	logic        mail1FlagN, mail2FlagN, parityErrAN, parityErrBN;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [35:0] portADataOut, portBDataOut;
	wire         writePortClock, portASelectN, portAEnable, portAWriteSel;
	wire         portAMailSel, readPortClock, portBSelectN, portBEnable;
	wire         portBReadSel, portBMailSel;
	wire  [35:0] aDrive, bDrive, portADataIn, portBDataIn;
	int          mismatches = 0;
	int          cmp_count = 0;
	int          off;
	dcf_top dcf_top_inst (.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .writePortClock,
		.portASelectN, .portAEnable, .portAWriteSel, .portAMailSel,
		.portADataIn, .portADataOut, .portADataOe, .readPortClock,
		.portBSelectN, .portBEnable, .portBReadSel, .portBMailSel,
		.portBDataIn, .portBDataOut, .portBDataOe, .offsetSelect0,
		.offsetSelect1, .fullFlagN, .almostFullFlagN, .emptyFlagN,
		.almostEmptyFlagN, .mail1FlagN, .mail2FlagN, .parityErrAN,
		.parityErrBN);
	dcf_port_model #(.PER(8)) portA (.coreClk(core_clk),
		.portClk(writePortClock), .selN(portASelectN), .en(portAEnable),
		.dirSel(portAWriteSel), .mailSel(portAMailSel), .drive(aDrive),
		.dout(portADataOut));
	dcf_port_model #(.PER(10)) portB (.coreClk(core_clk),
		.portClk(readPortClock), .selN(portBSelectN), .en(portBEnable),
		.dirSel(portBReadSel), .mailSel(portBMailSel), .drive(bDrive),
		.dout(portBDataOut));
	// Device wins the shared bus while its enable is high
	assign portADataIn = portADataOe ? portADataOut : aDrive;
	assign portBDataIn = portBDataOe ? portBDataOut : bDrive;
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	function logic [3:0] flags(int n);
		return {n > off, n > 0, 64 - n > off, n < 64};
	endfunction
	function logic [35:0] gen(logic [35:0] w, logic odd);
		for (int i = 0; i < 4; i++) w[9*i+8] = ^w[9*i +: 8] ^ odd;
		return w;
	endfunction
	function logic [35:0] rnd();
		return {4'($urandom), $urandom};
	endfunction
	task chk(logic [35:0] got, logic [35:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task axw(logic [3:0] a, logic [31:0] d, logic [1:0] e);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin
				@(posedge core_clk iff s_axi_awready);
				s_axi_awvalid <= 1'b0;
			end
			begin
				@(posedge core_clk iff s_axi_wready);
				s_axi_wvalid <= 1'b0;
			end
		join
		@(posedge core_clk iff s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, e);
	endtask
	task axr(logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge core_clk iff s_axi_arready);
		s_axi_arvalid <= 1'b0;
		@(posedge core_clk iff s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	// Status after both flag domains have settled
	task stat(int n);
		logic [31:0] d;
		logic [1:0] r;
		repeat (30) @(posedge core_clk);
		axr(4'h4, d, r);
		chk(d[3:0], flags(n));
		chk(d[14:4], {off[6:0], 4'hF});
		axr(4'h8, d, r);
		chk(d, n);
		chk(r, 2'h0);
	endtask
	task summarize();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#1000000;
		mismatches++;
		summarize();
	end
	initial begin
		logic [35:0] q[$];
		logic [35:0] w, r, last;
		logic [31:0] d;
		logic [1:0] rs;
		int n;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, arst_n} = '0;
		s_axi_wstrb = 4'hF;
		void'($urandom(38));
		n = $urandom % 4;
		{offsetSelect1, offsetSelect0} = 2'(n);
		off = 4 << n;
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		stat(0);
		axr(4'h0, d, rs);
		chk(d, 32'h0);
		axr(4'hC, d, rs);
		chk(rs, 2'h3);
		axw(4'hC, 32'h7, 2'h3);
		$display("test reset and registers done");
		for (n = 1; n <= 65; n++) begin
			w = rnd();
			portA.xfer(1'b1, 1'b0, w, r);
			if (n <= 64) q.push_back(w);
			if (n == 63 - off || n == 64 - off || n == 64) stat(n);
		end
		for (n = 64; n >= 0; n--) begin
			if (n == off || n == off + 1) stat(n);
			portB.xfer(1'b1, 1'b0, 36'h0, r);
			chk(r, (n > 0) ? q.pop_front() : last);
			last = r;
		end
		stat(0);
		$display("test fill and drain done");
		w = rnd();
		portA.xfer(1'b1, 1'b1, w, r);
		chk(mail1FlagN, 1'b0);
		portA.xfer(1'b1, 1'b1, ~w, r);
		portB.xfer(1'b1, 1'b1, 36'h0, r);
		chk(r, w);
		chk(mail1FlagN, 1'b1);
		portB.xfer(1'b0, 1'b1, ~w, r);
		chk(mail2FlagN, 1'b0);
		portA.xfer(1'b0, 1'b1, 36'h0, r);
		chk(r, ~w);
		chk(mail2FlagN, 1'b1);
		$display("test mailboxes done");
		axw(4'h0, 32'h4, 2'h0);
		w = rnd();
		fork
			portA.xfer(1'b1, 1'b0, w, r);
			begin
				@(posedge core_clk iff !portASelectN);
				repeat (4) @(posedge core_clk);
				chk(parityErrAN, w === gen(w, 1'b0));
			end
		join
		stat(1);
		portB.xfer(1'b1, 1'b0, 36'h0, r);
		chk(r, gen(w, 1'b0));
		axw(4'h0, 32'h3, 2'h0);
		w = rnd();
		fork
			portB.xfer(1'b0, 1'b1, w, r);
			begin
				@(posedge core_clk iff !portBSelectN);
				repeat (4) @(posedge core_clk);
				chk(parityErrBN, w === gen(w, 1'b1));
			end
		join
		portA.xfer(1'b0, 1'b1, 36'h0, r);
		chk(r, gen(w, 1'b1));
		axw(4'h0, 32'h0, 2'h0);
		$display("test parity generation done");
		for (n = 0; n < 16; n++) q.push_back(rnd());
		for (n = 0; n < 4; n++) portA.xfer(1'b1, 1'b0, q[n], r);
		stat(4);
		fork
			for (int i = 4; i < 16; i++) portA.xfer(1'b1, 1'b0, q[i], w);
			for (int j = 0; j < 16; j++) begin
				portB.xfer(1'b1, 1'b0, 36'h0, r);
				chk(r, q[j]);
			end
		join
		$display("test concurrent ports done");
		summarize();
	end
endmodule // dcf_top_bench
bind dcf_top dcf_chk dcf_chk_inst (.core_clk, .arst_n, .writePortClock,
	.readPortClock, .portASelectN, .portAWriteSel, .portAMailSel,
	.portADataOe, .portBSelectN, .portBEnable, .portBReadSel, .portBMailSel,
	.portBDataOe, .portBDataOut, .fullFlagN, .almostFullFlagN, .emptyFlagN,
	.almostEmptyFlagN, .mail1FlagN, .mail2FlagN);
`default_nettype wire
